// ---- src/opc_regs.sv ----
// output three-state, power and audio clock control register bank
`timescale 1ns/1ps

// Behaviour
// - pixel outputs driven only while enables set
// - bits 7/6 float pixel and sync outputs
// - bit 5 floats coaxial audio output
// - bit 4 floats serial audio and clock
// - bit 3 picks power-down pin polarity
// - pin function field; bit 0 forces power-down
// - auto low power only when enabled
// - bit 6 is protection port address lsb
// - bit 5 selects external audio master clock
// - bit 4 inserts timing reference codes
// - dvi mode plus bit 3 uses internal enable
// - modes 1 and 2 add double-rate data on blue
module opc_regs (
  input wire logic clk_sys,
  input wire logic rst,
  input wire opc_pkg::opc_req_t req,
  input wire logic pwrdn_pin,
  input wire logic dvi_mode,
  input wire logic link_idle,
  output logic [7:0] rd_data,
  output opc_pkg::opc_ctl_t ctl
);

  ////////////////////////////////////////////////////////////////////////////
  // register storage

  logic [7:0] sel_q;
  logic [7:0] tri_q;
  logic [7:0] aud_q;
  logic [7:0] rd_data_q;
  opc_pkg::opc_ctl_t ctl_q;
  opc_pkg::opc_ctl_t ctl_d;

  function automatic logic [7:0] reg_next(input logic [7:0] old, input logic hit,
                                           input logic [7:0] wdata, input logic [7:0] mask);
    reg_next = hit ? (wdata & mask) : old;
  endfunction

  wire hit_sel = req.wr && (req.addr == opc_pkg::OPC_ADDR_OUT_SEL);
  wire hit_tri = req.wr && (req.addr == opc_pkg::OPC_ADDR_TRI_PWR);
  wire hit_aud = req.wr && (req.addr == opc_pkg::OPC_ADDR_PWR_AUD);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sel_q <= opc_pkg::OPC_RST_OUT_SEL;
      tri_q <= opc_pkg::OPC_RST_TRI_PWR;
      aud_q <= opc_pkg::OPC_RST_PWR_AUD;
    end else begin
      sel_q <= reg_next(sel_q, hit_sel, req.wdata, opc_pkg::OPC_MASK_OUT_SEL);
      tri_q <= reg_next(tri_q, hit_tri, req.wdata, opc_pkg::OPC_MASK_TRI_PWR);
      aud_q <= reg_next(aud_q, hit_aud, req.wdata, opc_pkg::OPC_MASK_PWR_AUD);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read back; unmapped offsets answer zero

  wire [7:0] rd_mux = (req.addr == opc_pkg::OPC_ADDR_OUT_SEL) ? sel_q :
                      (req.addr == opc_pkg::OPC_ADDR_TRI_PWR) ? tri_q :
                      (req.addr == opc_pkg::OPC_ADDR_PWR_AUD) ? aud_q : 8'h00;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_data_q <= 8'h00;
    end else if (req.rd) begin
      rd_data_q <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power-down pin decode

  // polarity bit turns the raw pin into an asserted level
  wire pin_asserted = tri_q[opc_pkg::OPC_PD_POL_BIT] ? pwrdn_pin : !pwrdn_pin;
  wire opc_pkg::opc_pd_fn_t pd_fn = opc_pkg::opc_pd_fn_t'(tri_q[opc_pkg::OPC_PD_FN_LSB +: 2]);
  wire pin_pd = pin_asserted && ((pd_fn == opc_pkg::OPC_PDF_PWRDN) ||
                                 (pd_fn == opc_pkg::OPC_PDF_PWRDN_SOG));
  wire pin_float = pin_asserted && ((pd_fn == opc_pkg::OPC_PDF_FLOAT) ||
                                    (pd_fn == opc_pkg::OPC_PDF_FLOAT_SOG));
  wire pin_sog_float = pin_asserted && ((pd_fn == opc_pkg::OPC_PDF_PWRDN_SOG) ||
                                        (pd_fn == opc_pkg::OPC_PDF_FLOAT_SOG));

  ////////////////////////////////////////////////////////////////////////////
  // output control decode

  wire opc_pkg::opc_mode_t mode = opc_pkg::opc_mode_t'(sel_q[opc_pkg::OPC_MODE_LSB +: 2]);
  // secondary port only carries data in the two double-rate modes
  wire sec_mode = (mode == opc_pkg::OPC_MODE_422_DDR) || (mode == opc_pkg::OPC_MODE_DDR444);
  wire pix_drive = !tri_q[opc_pkg::OPC_PIX_TRI_BIT] && !pin_float;

  always_comb begin
    ctl_d = opc_pkg::OPC_CTL_RST;
    ctl_d.pix_primary_oe = pix_drive && sel_q[opc_pkg::OPC_PRI_EN_BIT];
    ctl_d.pix_secondary_oe = pix_drive && sel_q[opc_pkg::OPC_SEC_EN_BIT] && sec_mode;
    ctl_d.out_mode = mode;
    ctl_d.sync_on_green_out_oe = !tri_q[opc_pkg::OPC_SOG_TRI_BIT] && !pin_sog_float;
    ctl_d.spdif_oe = !tri_q[opc_pkg::OPC_SPDIF_TRI_BIT];
    ctl_d.i2s_oe = !tri_q[opc_pkg::OPC_I2S_TRI_BIT];
    ctl_d.power_down = pin_pd || tri_q[opc_pkg::OPC_PD_FORCE_BIT];
    ctl_d.low_power = aud_q[opc_pkg::OPC_AUTO_PD_BIT] && link_idle;
    ctl_d.protection_port_addr_lsb = aud_q[opc_pkg::OPC_ADDR_LSB_BIT];
    // with the external clock the source must track the video clock or samples slip
    ctl_d.mclk_external_sel = aud_q[opc_pkg::OPC_MCLK_EXT_BIT];
    ctl_d.timing_code_insert_enable = aud_q[opc_pkg::OPC_TC_INS_BIT];
    ctl_d.force_internal_enable_gen = aud_q[opc_pkg::OPC_FORCE_DE_BIT] && dvi_mode;
  end

  // one register stage: a write lands one clock, outputs follow the next
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctl_q <= opc_pkg::OPC_CTL_RST;
    end else begin
      ctl_q <= ctl_d;
    end
  end

  assign ctl = ctl_q;
  assign rd_data = rd_data_q;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // pin level that the polarity bit calls asserted
  wire pin_on = (pwrdn_pin == tri_q[opc_pkg::OPC_PD_POL_BIT]);

  sequence s_quiet_tri;
    !hit_tri;
  endsequence

  property p_pri_disable;
    hit_sel && !req.wdata[opc_pkg::OPC_PRI_EN_BIT] ##1 !hit_sel |=> !ctl_q.pix_primary_oe;
  endproperty
  a_pri_disable: assert property (p_pri_disable) else $error("primary driven while disabled");

  property p_sec_mode;
    ctl_q.pix_secondary_oe |-> ($past(sel_q[opc_pkg::OPC_MODE_LSB +: 2]) == opc_pkg::OPC_MODE_422_DDR) ||
                               ($past(sel_q[opc_pkg::OPC_MODE_LSB +: 2]) == opc_pkg::OPC_MODE_DDR444);
  endproperty
  a_sec_mode: assert property (p_sec_mode) else $error("secondary driven outside modes 1 and 2");

  property p_pix_float;
    hit_tri && req.wdata[opc_pkg::OPC_PIX_TRI_BIT] ##1 s_quiet_tri
      |=> !ctl_q.pix_primary_oe && !ctl_q.pix_secondary_oe;
  endproperty
  a_pix_float: assert property (p_pix_float) else $error("pixel outputs not floated");

  property p_sog_float;
    hit_tri && req.wdata[opc_pkg::OPC_SOG_TRI_BIT] ##1 s_quiet_tri |=> !ctl_q.sync_on_green_out_oe;
  endproperty
  a_sog_float: assert property (p_sog_float) else $error("sync output not floated");

  property p_spdif;
    hit_tri ##1 s_quiet_tri |=> ctl_q.spdif_oe == !$past(req.wdata[opc_pkg::OPC_SPDIF_TRI_BIT], 2);
  endproperty
  a_spdif: assert property (p_spdif) else $error("coaxial audio enable wrong");

  property p_i2s;
    hit_tri ##1 s_quiet_tri |=> ctl_q.i2s_oe == !$past(req.wdata[opc_pkg::OPC_I2S_TRI_BIT], 2);
  endproperty
  a_i2s: assert property (p_i2s) else $error("serial audio enable wrong");

  property p_pin_low;
    !tri_q[opc_pkg::OPC_PD_POL_BIT] && (pd_fn == opc_pkg::OPC_PDF_PWRDN) && !pwrdn_pin |=> ctl_q.power_down;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("active-low pin did not power down");

  property p_pin_float;
    pin_on && (pd_fn == opc_pkg::OPC_PDF_FLOAT) && !tri_q[opc_pkg::OPC_PD_FORCE_BIT]
      && !tri_q[opc_pkg::OPC_SOG_TRI_BIT] |=> !ctl_q.power_down && !ctl_q.pix_primary_oe && ctl_q.sync_on_green_out_oe;
  endproperty
  a_pin_float: assert property (p_pin_float) else $error("float-only pin function wrong");

  property p_force_pd;
    tri_q[opc_pkg::OPC_PD_FORCE_BIT] |=> ctl_q.power_down;
  endproperty
  a_force_pd: assert property (p_force_pd) else $error("forced power-down ignored");

  property p_low_power;
    ctl_q.low_power |-> $past(aud_q[opc_pkg::OPC_AUTO_PD_BIT]) && $past(link_idle);
  endproperty
  a_low_power: assert property (p_low_power) else $error("low power entered while disabled");

  property p_addr_lsb;
    hit_aud ##1 !hit_aud |=> ctl_q.protection_port_addr_lsb == $past(req.wdata[opc_pkg::OPC_ADDR_LSB_BIT], 2);
  endproperty
  a_addr_lsb: assert property (p_addr_lsb) else $error("address lsb not applied");

  property p_mclk;
    hit_aud ##1 !hit_aud |=> ctl_q.mclk_external_sel == $past(req.wdata[opc_pkg::OPC_MCLK_EXT_BIT], 2);
  endproperty
  a_mclk: assert property (p_mclk) else $error("audio clock source not applied");

  property p_tc_ins;
    hit_aud ##1 !hit_aud |=> ctl_q.timing_code_insert_enable == $past(req.wdata[opc_pkg::OPC_TC_INS_BIT], 2);
  endproperty
  a_tc_ins: assert property (p_tc_ins) else $error("timing code insert not applied");

  property p_force_de;
    ctl_q.force_internal_enable_gen |-> $past(dvi_mode) && $past(aud_q[opc_pkg::OPC_FORCE_DE_BIT]);
  endproperty
  a_force_de: assert property (p_force_de) else $error("internal enable outside dvi mode");

  property p_latency;
    hit_sel && req.wdata[opc_pkg::OPC_PRI_EN_BIT] && !tri_q[opc_pkg::OPC_PIX_TRI_BIT] && !pin_float
      ##1 (!hit_sel && !hit_tri && !pin_float) |=> ctl_q.pix_primary_oe;
  endproperty
  a_latency: assert property (p_latency) else $error("enable not applied in time");

  ////////////////////////////////////////////////////////////////////////////
  // state checks; the !rst guard skips the edge where ctl still shows its reset image

  property p_pri_only;
    ctl_q.pix_primary_oe |-> $past(sel_q[opc_pkg::OPC_PRI_EN_BIT]);
  endproperty
  a_pri_only: assert property (p_pri_only) else $error("primary driven with enable clear");

  property p_sec_only;
    ctl_q.pix_secondary_oe |-> $past(sel_q[opc_pkg::OPC_SEC_EN_BIT]);
  endproperty
  a_sec_only: assert property (p_sec_only) else $error("secondary driven with enable clear");

  property p_pix_tri_hold;
    tri_q[opc_pkg::OPC_PIX_TRI_BIT] |=> !ctl_q.pix_primary_oe && !ctl_q.pix_secondary_oe;
  endproperty
  a_pix_tri_hold: assert property (p_pix_tri_hold) else $error("pixel outputs driven while floated");

  property p_sog_tri_hold;
    tri_q[opc_pkg::OPC_SOG_TRI_BIT] |=> !ctl_q.sync_on_green_out_oe;
  endproperty
  a_sog_tri_hold: assert property (p_sog_tri_hold) else $error("sync output driven while floated");

  property p_spdif_state;
    !rst |=> ctl_q.spdif_oe == !$past(tri_q[opc_pkg::OPC_SPDIF_TRI_BIT]);
  endproperty
  a_spdif_state: assert property (p_spdif_state) else $error("coaxial audio enable off its bit");

  property p_i2s_state;
    !rst |=> ctl_q.i2s_oe == !$past(tri_q[opc_pkg::OPC_I2S_TRI_BIT]);
  endproperty
  a_i2s_state: assert property (p_i2s_state) else $error("serial audio enable off its bit");

  property p_pin_high;
    tri_q[opc_pkg::OPC_PD_POL_BIT] && (pd_fn == opc_pkg::OPC_PDF_PWRDN) && pwrdn_pin |=> ctl_q.power_down;
  endproperty
  a_pin_high: assert property (p_pin_high) else $error("active-high pin did not power down");

  property p_pin_idle;
    !tri_q[opc_pkg::OPC_PD_FORCE_BIT] && !pin_on |=> !ctl_q.power_down;
  endproperty
  a_pin_idle: assert property (p_pin_idle) else $error("power-down with pin not asserted");

  property p_pin_pd_sog;
    pin_on && (pd_fn == opc_pkg::OPC_PDF_PWRDN_SOG) |=> ctl_q.power_down && !ctl_q.sync_on_green_out_oe;
  endproperty
  a_pin_pd_sog: assert property (p_pin_pd_sog) else $error("power-down with sync float wrong");

  property p_pin_float_sog;
    pin_on && (pd_fn == opc_pkg::OPC_PDF_FLOAT_SOG)
      |=> !ctl_q.pix_primary_oe && !ctl_q.pix_secondary_oe && !ctl_q.sync_on_green_out_oe;
  endproperty
  a_pin_float_sog: assert property (p_pin_float_sog) else $error("float with sync function wrong");

  property p_low_power_on;
    aud_q[opc_pkg::OPC_AUTO_PD_BIT] && link_idle |=> ctl_q.low_power;
  endproperty
  a_low_power_on: assert property (p_low_power_on) else $error("enabled low power not entered");

  property p_addr_lsb_state;
    !rst |=> ctl_q.protection_port_addr_lsb == $past(aud_q[opc_pkg::OPC_ADDR_LSB_BIT]);
  endproperty
  a_addr_lsb_state: assert property (p_addr_lsb_state) else $error("address lsb off its bit");

  property p_mclk_state;
    !rst |=> ctl_q.mclk_external_sel == $past(aud_q[opc_pkg::OPC_MCLK_EXT_BIT]);
  endproperty
  a_mclk_state: assert property (p_mclk_state) else $error("audio clock source off its bit");

  property p_tc_state;
    !rst |=> ctl_q.timing_code_insert_enable == $past(aud_q[opc_pkg::OPC_TC_INS_BIT]);
  endproperty
  a_tc_state: assert property (p_tc_state) else $error("timing code insert off its bit");

  property p_force_de_on;
    dvi_mode && aud_q[opc_pkg::OPC_FORCE_DE_BIT] |=> ctl_q.force_internal_enable_gen;
  endproperty
  a_force_de_on: assert property (p_force_de_on) else $error("internal enable not used in dvi mode");

  property p_mode_out;
    !rst |=> ctl_q.out_mode == $past(sel_q[opc_pkg::OPC_MODE_LSB +: 2]);
  endproperty
  a_mode_out: assert property (p_mode_out) else $error("output mode off its field");

  c_pix_float: cover property (hit_tri && req.wdata[opc_pkg::OPC_PIX_TRI_BIT] ##2 !ctl_q.pix_primary_oe);
  c_pin_pd: cover property (ctl_q.power_down && !tri_q[opc_pkg::OPC_PD_FORCE_BIT]);
  c_sec_on: cover property (ctl_q.pix_secondary_oe);
  c_low_power: cover property (ctl_q.low_power);
  c_pin_sog: cover property (ctl_q.power_down && !ctl_q.sync_on_green_out_oe);

endmodule

// ---- src/opc_pkg.sv ----
// package of offsets, fields, reset values and carrier types for the output and power control bank
package opc_pkg;
  localparam logic [7:0] OPC_ADDR_OUT_SEL = 8'h25;
  localparam logic [7:0] OPC_ADDR_TRI_PWR = 8'h26;
  localparam logic [7:0] OPC_ADDR_PWR_AUD = 8'h27;
  // output select register fields
  localparam int OPC_SEC_EN_BIT = 0;
  localparam int OPC_PRI_EN_BIT = 1;
  localparam int OPC_MODE_LSB = 2;
  // three-state and power register fields
  localparam int OPC_PD_FORCE_BIT = 0;
  localparam int OPC_PD_FN_LSB = 1;
  localparam int OPC_PD_POL_BIT = 3;
  localparam int OPC_I2S_TRI_BIT = 4;
  localparam int OPC_SPDIF_TRI_BIT = 5;
  localparam int OPC_SOG_TRI_BIT = 6;
  localparam int OPC_PIX_TRI_BIT = 7;
  // power, audio clock and timing register fields
  localparam int OPC_FORCE_DE_BIT = 3;
  localparam int OPC_TC_INS_BIT = 4;
  localparam int OPC_MCLK_EXT_BIT = 5;
  localparam int OPC_ADDR_LSB_BIT = 6;
  localparam int OPC_AUTO_PD_BIT = 7;
  // reset values and implemented-bit masks
  localparam logic [7:0] OPC_RST_OUT_SEL = 8'h02;
  localparam logic [7:0] OPC_RST_TRI_PWR = 8'h08;
  localparam logic [7:0] OPC_RST_PWR_AUD = 8'h80;
  localparam logic [7:0] OPC_MASK_OUT_SEL = 8'h0f;
  localparam logic [7:0] OPC_MASK_TRI_PWR = 8'hff;
  localparam logic [7:0] OPC_MASK_PWR_AUD = 8'hf8;

  typedef enum logic [1:0] {
    OPC_MODE_444 = 2'h0,
    OPC_MODE_422_DDR = 2'h1,
    OPC_MODE_DDR444 = 2'h2,
    OPC_MODE_422_12B = 2'h3
  } opc_mode_t;

  typedef enum logic [1:0] {
    OPC_PDF_PWRDN = 2'h0,
    OPC_PDF_PWRDN_SOG = 2'h1,
    OPC_PDF_FLOAT = 2'h2,
    OPC_PDF_FLOAT_SOG = 2'h3
  } opc_pd_fn_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } opc_req_t;

  typedef struct packed {
    logic pix_primary_oe;
    logic pix_secondary_oe;
    opc_mode_t out_mode;
    logic sync_on_green_out_oe;
    logic spdif_oe;
    logic i2s_oe;
    logic power_down;
    logic low_power;
    logic protection_port_addr_lsb;
    logic mclk_external_sel;
    logic timing_code_insert_enable;
    logic force_internal_enable_gen;
  } opc_ctl_t;

  localparam opc_ctl_t OPC_CTL_RST = '0;
endpackage

// ---- tb/opc_host.sv ----
// host controller model for the register port of the control bank
`timescale 1ns/1ps
// the address lsb is driven both ways through this host: the bench writes 8'h40 and then 8'h80 to 8'h27
// no audio clock is modelled; an external one is taken as locked to video
module opc_host (
  input wire logic clk_sys,
  input wire logic [7:0] rd_data,
  output opc_pkg::opc_req_t req
);
  initial req = '0;
  //////////////////////////////
  // strobe held through the taking edge, released just after it
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clk_sys);
    req <= '0;
  endtask
  // sampled one edge late, where the held read data is settled either way
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys);
    req <= '0;
    @(posedge clk_sys);
    #1 v = rd_data;
  endtask
endmodule

// ---- tb/output_power_control_regs_test.sv ----
// self-checking bench for the output and power control bank
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module output_power_control_regs_test;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic pwrdn_pin = 1'b0;
  logic dvi_mode = 1'b0;
  logic link_idle = 1'b0;
  opc_pkg::opc_req_t req;
  logic [7:0] rd_data;
  opc_pkg::opc_ctl_t ctl;
  logic [7:0] r25 = 8'h02, r26 = 8'h08, r27 = 8'h80, d;
  int mismatches = 0;
  int checked = 0;
  always #12.5 clk_sys = ~clk_sys;
  opc_host opc_host_inst (.clk_sys(clk_sys), .rd_data(rd_data), .req(req));
  opc_regs opc_regs_inst (.clk_sys(clk_sys), .rst(rst), .req(req), .pwrdn_pin(pwrdn_pin),
    .dvi_mode(dvi_mode), .link_idle(link_idle), .rd_data(rd_data), .ctl(ctl));
  //////////////////////////////
  function automatic opc_pkg::opc_ctl_t exp_ctl();
    opc_pkg::opc_ctl_t c;
    logic act;
    logic [1:0] fn;
    c = '0;
    act = (pwrdn_pin == r26[3]);
    fn = act ? r26[2:1] : 2'h0;
    c.pix_primary_oe = r25[1] && !r26[7] && !fn[1];
    c.pix_secondary_oe = r25[0] && (r25[3:2] == 2'h1 || r25[3:2] == 2'h2) && !r26[7] && !fn[1];
    c.out_mode = opc_pkg::opc_mode_t'(r25[3:2]);
    c.sync_on_green_out_oe = !r26[6] && !fn[0];
    c.spdif_oe = !r26[5];
    c.i2s_oe = !r26[4];
    c.power_down = r26[0] || (act && !fn[1]);
    c.low_power = r27[7] && link_idle;
    c.protection_port_addr_lsb = r27[6];
    c.mclk_external_sel = r27[5];
    c.timing_code_insert_enable = r27[4];
    c.force_internal_enable_gen = dvi_mode && r27[3];
    return c;
  endfunction
  // ctl is checked at the first settled point after the write, so a late update shows
  task automatic put(input logic [7:0] a, input logic [7:0] v);
    if (a == opc_pkg::OPC_ADDR_OUT_SEL) r25 = v & opc_pkg::OPC_MASK_OUT_SEL;
    if (a == opc_pkg::OPC_ADDR_TRI_PWR) r26 = v & opc_pkg::OPC_MASK_TRI_PWR;
    if (a == opc_pkg::OPC_ADDR_PWR_AUD) r27 = v & opc_pkg::OPC_MASK_PWR_AUD;
    opc_host_inst.wr(a, v);
    @(posedge clk_sys);
    #1 `CHK("ctl after write", exp_ctl(), ctl)
  endtask
  task automatic get(input logic [7:0] a, input logic [7:0] e);
    opc_host_inst.rd(a, d);
    `CHK("read data", e, d)
  endtask
  // pins are only promised one edge of delay; three edges leave margin
  task automatic pins(input logic p, input logic dv, input logic li);
    @(posedge clk_sys);
    pwrdn_pin <= p;
    dvi_mode <= dv;
    link_idle <= li;
    repeat (3) @(posedge clk_sys);
    #1 `CHK("ctl after pins", exp_ctl(), ctl)
  endtask
  task automatic wrap_up();
    $display("counts checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  //////////////////////////////
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    wrap_up();
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 `CHK("ctl after reset", exp_ctl(), ctl)
    get(8'h25, 8'h02);
    get(8'h26, 8'h08);
    get(8'h27, 8'h80);
    get(8'h30, 8'h00);
    $display("test reset done");
    for (int m = 0; m < 4; m++) begin
      put(8'h25, {4'hf, m[1:0], 2'h3});
      get(8'h25, {4'h0, m[1:0], 2'h3});
    end
    put(8'h25, 8'h05);
    put(8'h25, 8'h02);
    $display("test output enables done");
    for (int i = 4; i < 8; i++) begin
      put(8'h26, 8'h08 | (8'h01 << i));
      get(8'h26, 8'h08 | (8'h01 << i));
    end
    $display("test three-state done");
    for (int k = 0; k < 8; k++) begin
      put(8'h26, {4'h0, k[2], k[1:0], 1'b0});
      pins(1'b1, 1'b0, 1'b0);
      pins(1'b0, 1'b0, 1'b0);
    end
    put(8'h26, 8'h09);
    $display("test power-down pin done");
    for (int i = 3; i < 8; i++) begin
      put(8'h27, 8'h01 << i);
      pins(1'b0, 1'b1, 1'b1);
      pins(1'b0, 1'b0, 1'b0);
    end
    put(8'h27, 8'hff);
    get(8'h27, 8'hf8);
    put(8'h30, 8'hff);
    get(8'h30, 8'h00);
    get(8'h26, 8'h09);
    $display("test power and audio clock done");
    wrap_up();
  end
endmodule
